/* File: design/crsf_pkg.sv */
// Contract
// - Load CRC preset on tx, rx, calculate
// - Low seed byte resets to FEh
// - High seed byte resets to FFh
// - Short checksum mode ignores high byte
// - Slot interval timed from command end
// - Quit frame timed from command start
// - Select bit 4 extends slot interval
// - Probe select codes route internal signals
// - Probe select resets to 00h, pin low
// - Near-full when free space <= watermark
// - Near-empty when entries <= watermark
// - Watermark register resets to 3Eh
package crsf_pkg;
  // Host port address width, covers 00h to 3Fh
  localparam int ADDR_W = 6;
  // Register offsets on the host parallel port
  localparam logic [5:0] ADR_SEED_LOW = 6'h23;
  localparam logic [5:0] ADR_SEED_HIGH = 6'h24;
  localparam logic [5:0] ADR_SLOT = 6'h25;
  localparam logic [5:0] ADR_PROBE_SEL = 6'h26;
  localparam logic [5:0] ADR_RSVD_A = 6'h27;
  localparam logic [5:0] ADR_WATERMARK = 6'h29;
  // Reset values
  localparam logic [7:0] RST_SEED_LOW = 8'hFE;
  localparam logic [7:0] RST_SEED_HIGH = 8'hFF;
  localparam logic [7:0] RST_SLOT = 8'h00;
  localparam logic [7:0] RST_PROBE_SEL = 8'h00;
  localparam logic [7:0] RST_RSVD_A = 8'h00;
  localparam logic [7:0] RST_WATERMARK = 8'h3E;
  // Field layout of the probe select register
  localparam int SLOT_TOP_POS = 4;
  localparam int SEL_W = 3;
  // Field layout of the watermark register
  localparam int WM_W = 6;
  // Slot interval width, eight bits plus the extension bit
  localparam int SLOT_W = 9;
  // FIFO geometry seen by the alert logic
  localparam int FIFO_DEPTH = 64;
  localparam int CNT_W = 7;
  // Probe pin routing codes
  localparam logic [2:0] PRB_LOW = 3'h0;
  localparam logic [2:0] PRB_HIGH = 3'h1;
  localparam logic [2:0] PRB_ENVELOPE = 3'h2;
  localparam logic [2:0] PRB_SERIAL = 3'h3;
  localparam logic [2:0] PRB_CARRIER = 3'h4;
  localparam logic [2:0] PRB_SUBCARRIER = 3'h5;
  // Slot timer states, one-hot
  typedef enum logic [2:0] {
    SLOT_IDLE = 3'h1,
    SLOT_COUNT = 3'h2,
    SLOT_FIRE = 3'h4
  } crsf_slot_st_t;
endpackage

/* File: design/crsf_probe_mux.sv */
`timescale 1ns/1ps
module crsf_probe_mux (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [crsf_pkg::SEL_W-1:0] i_sel,
  input wire logic i_envelope,
  input wire logic i_serial_data,
  input wire logic i_carrier_demod,
  input wire logic i_subcarrier_demod,
  output logic o_probe_pin
);
  import crsf_pkg::*;

  logic probe_r; // Registered pin level, avoids glitches on code change
  logic probe_nxt;

  // Route the chosen internal signal
  always_comb begin
    case (i_sel)
      PRB_LOW: probe_nxt = 1'b0;
      PRB_HIGH: probe_nxt = 1'b1;
      PRB_ENVELOPE: probe_nxt = i_envelope;
      PRB_SERIAL: probe_nxt = i_serial_data;
      PRB_CARRIER: probe_nxt = i_carrier_demod;
      PRB_SUBCARRIER: probe_nxt = i_subcarrier_demod;
      // Reserved codes park the pin low
      default: probe_nxt = 1'b0;
    endcase
  end

  // Pin register, low during reset
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      probe_r <= 1'b0;
    end else begin
      probe_r <= probe_nxt;
    end
  end

  assign o_probe_pin = probe_r;

  property p_probe_const;
    @(posedge i_clk) disable iff (i_rst)
    (i_sel == PRB_LOW || i_sel > PRB_SUBCARRIER) |=> !o_probe_pin;
  endproperty
  a_probe_const:
    assert property (p_probe_const) else $error("probe not low");

  property p_probe_route;
    @(posedge i_clk) disable iff (i_rst)
    (i_sel == PRB_CARRIER) |=> (o_probe_pin == $past(i_carrier_demod));
  endproperty
  a_probe_route:
    assert property (p_probe_route) else $error("probe route");
endmodule

/* File: design/crsf_level_alert.sv */
`timescale 1ns/1ps
module crsf_level_alert #(
  parameter int DEPTH = crsf_pkg::FIFO_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [crsf_pkg::WM_W-1:0] i_watermark,
  input wire logic [crsf_pkg::CNT_W-1:0] i_fifo_count,
  output logic o_near_full,
  output logic o_near_empty
);
  import crsf_pkg::*;

  logic full_r; // Near-full flag
  logic empty_r; // Near-empty flag
  logic full_nxt;
  logic empty_nxt;
  logic [CNT_W-1:0] free_space; // Entries still free
  logic [CNT_W-1:0] wm_ext; // Watermark at count width

  // Compare fill and free space with the watermark
  always_comb begin
    free_space = CNT_W'(DEPTH) - i_fifo_count;
    wm_ext = {1'b0, i_watermark};
    full_nxt = (free_space <= wm_ext);
    empty_nxt = (i_fifo_count <= wm_ext);
  end

  // Flags are levels that follow the FIFO one cycle later
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      full_r <= 1'b0;
      empty_r <= 1'b1;
    end else begin
      full_r <= full_nxt;
      empty_r <= empty_nxt;
    end
  end

  assign o_near_full = full_r;
  assign o_near_empty = empty_r;

  property p_near_full;
    @(posedge i_clk) disable iff (i_rst)
    1'b1 |=> (o_near_full ==
      ((CNT_W'(DEPTH) - $past(i_fifo_count)) <= {1'b0, $past(i_watermark)}));
  endproperty
  a_near_full: assert property (p_near_full) else $error("near full");

  property p_near_empty;
    @(posedge i_clk) disable iff (i_rst)
    ({1'b0, i_watermark} < i_fifo_count) |=> !o_near_empty;
  endproperty
  a_near_empty:
    assert property (p_near_empty) else $error("near empty");

  c_full: cover property (@(posedge i_clk) disable iff (i_rst) o_near_full);
endmodule

/* File: design/crsf_cfg_top.sv */
`timescale 1ns/1ps
module crsf_cfg_top (
  input wire logic I_SYS_CLK,
  input wire logic I_SYS_RST,
  // Host parallel port, synchronous strobes
  input wire logic [crsf_pkg::ADDR_W-1:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [7:0] O_RDATA,
  // CRC load events and mode from the framing logic
  input wire logic I_TX_BEGIN,
  input wire logic I_RX_BEGIN,
  input wire logic I_CALC_CMD,
  input wire logic I_CRC_EN,
  input wire logic I_SHORT_MODE,
  output logic O_CRC_LOAD,
  output logic [15:0] O_CRC_SEED,
  // Slot timing
  input wire logic I_CMD_TX_BEGIN,
  input wire logic I_CMD_TX_END,
  input wire logic I_QUIT_MODE,
  input wire logic I_SLOT_TICK,
  output logic O_SLOT_FIRE,
  // Probe pin sources
  input wire logic I_ENVELOPE,
  input wire logic I_SERIAL_DATA,
  input wire logic I_CARRIER_DEMOD,
  input wire logic I_SUBCARRIER_DEMOD,
  output logic O_PROBE_PIN,
  // FIFO fill level and alerts
  input wire logic [crsf_pkg::CNT_W-1:0] I_FIFO_COUNT,
  output logic O_NEAR_FULL_FLAG,
  output logic O_NEAR_EMPTY_FLAG
);
  import crsf_pkg::*;

  // Register file
  logic [7:0] seed_low_r; // Low CRC seed byte
  logic [7:0] seed_high_r; // High CRC seed byte
  logic [7:0] slot_r; // Slot interval, low eight bits
  logic [7:0] probe_sel_r; // Probe select plus slot top bit
  logic [7:0] rsvd_a_r; // Reserved, stored but unused
  logic [7:0] watermark_r; // Watermark register
  logic [7:0] seed_low_nxt;
  logic [7:0] seed_high_nxt;
  logic [7:0] slot_nxt;
  logic [7:0] probe_sel_nxt;
  logic [7:0] rsvd_a_nxt;
  logic [7:0] watermark_nxt;
  logic [7:0] rdata_r; // Read data holds until next read
  logic [7:0] rdata_nxt;

  // Register writes and read mux
  always_comb begin
    seed_low_nxt = seed_low_r;
    seed_high_nxt = seed_high_r;
    slot_nxt = slot_r;
    probe_sel_nxt = probe_sel_r;
    rsvd_a_nxt = rsvd_a_r;
    watermark_nxt = watermark_r;
    rdata_nxt = rdata_r;
    // Reserved bits are stored as written; the host keeps them
    if (I_WR) begin
      case (I_ADDR)
        ADR_SEED_LOW: seed_low_nxt = I_WDATA;
        ADR_SEED_HIGH: seed_high_nxt = I_WDATA;
        ADR_SLOT: slot_nxt = I_WDATA;
        ADR_PROBE_SEL: probe_sel_nxt = I_WDATA;
        ADR_RSVD_A: rsvd_a_nxt = I_WDATA;
        ADR_WATERMARK: watermark_nxt = I_WDATA;
        // Unmapped writes are dropped
        default: ;
      endcase
    end
    if (I_RD) begin
      case (I_ADDR)
        ADR_SEED_LOW: rdata_nxt = seed_low_r;
        ADR_SEED_HIGH: rdata_nxt = seed_high_r;
        ADR_SLOT: rdata_nxt = slot_r;
        ADR_PROBE_SEL: rdata_nxt = probe_sel_r;
        ADR_RSVD_A: rdata_nxt = rsvd_a_r;
        ADR_WATERMARK: rdata_nxt = watermark_r;
        // Unmapped reads return zero
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  // Register file flops
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      seed_low_r <= RST_SEED_LOW;
      seed_high_r <= RST_SEED_HIGH;
      slot_r <= RST_SLOT;
      probe_sel_r <= RST_PROBE_SEL;
      rsvd_a_r <= RST_RSVD_A;
      watermark_r <= RST_WATERMARK;
      rdata_r <= 8'h00;
    end else begin
      seed_low_r <= seed_low_nxt;
      seed_high_r <= seed_high_nxt;
      slot_r <= slot_nxt;
      probe_sel_r <= probe_sel_nxt;
      rsvd_a_r <= rsvd_a_nxt;
      watermark_r <= watermark_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign O_RDATA = rdata_r;

  // CRC seed delivery
  logic crc_event; // Any of the three load causes
  logic load_r; // One-cycle load strobe
  logic load_nxt;
  logic [15:0] seed_r; // Seed presented with the strobe
  logic [15:0] seed_nxt;

  // Seed is latched only at a load, so late writes wait for the next one
  always_comb begin
    crc_event = I_CRC_EN & (I_TX_BEGIN | I_RX_BEGIN | I_CALC_CMD);
    load_nxt = crc_event;
    seed_nxt = seed_r;
    if (crc_event) begin
      if (I_SHORT_MODE) begin
        seed_nxt = {8'h00, seed_low_r};
      end else begin
        seed_nxt = {seed_high_r, seed_low_r};
      end
    end
  end

  // Seed flops
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      load_r <= 1'b0;
      seed_r <= {RST_SEED_HIGH, RST_SEED_LOW};
    end else begin
      load_r <= load_nxt;
      seed_r <= seed_nxt;
    end
  end

  assign O_CRC_LOAD = load_r;
  assign O_CRC_SEED = seed_r;

  // Slot timer
  crsf_slot_st_t slot_st_r; // Timer state
  crsf_slot_st_t slot_st_nxt;
  logic [SLOT_W-1:0] slot_cnt_r; // Ticks left in the slot
  logic [SLOT_W-1:0] slot_cnt_nxt;
  logic [SLOT_W-1:0] period; // Full nine-bit interval
  logic slot_start; // Reference point of the slot

  // Count slot ticks from the chosen reference and fire once
  always_comb begin
    // select bit 4 as top bit
    period = {probe_sel_r[SLOT_TOP_POS], slot_r};
    slot_start = I_CMD_TX_END;
    if (I_QUIT_MODE) begin
      slot_start = I_CMD_TX_BEGIN;
    end
    slot_st_nxt = slot_st_r;
    slot_cnt_nxt = slot_cnt_r;
    case (slot_st_r)
      SLOT_IDLE: ;
      SLOT_COUNT: begin
        if (I_SLOT_TICK) begin
          slot_cnt_nxt = slot_cnt_r - SLOT_W'(1);
          if (slot_cnt_r == SLOT_W'(1)) begin
            slot_st_nxt = SLOT_FIRE;
          end
        end
      end
      SLOT_FIRE: slot_st_nxt = SLOT_IDLE;
      default: slot_st_nxt = SLOT_IDLE;
    endcase
    // A new reference restarts; a zero interval never fires
    if (slot_start) begin
      slot_cnt_nxt = period;
      if (period != '0) begin
        slot_st_nxt = SLOT_COUNT;
      end else begin
        slot_st_nxt = SLOT_IDLE;
      end
    end
  end

  // Slot timer flops
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      slot_st_r <= SLOT_IDLE;
      slot_cnt_r <= '0;
    end else begin
      slot_st_r <= slot_st_nxt;
      slot_cnt_r <= slot_cnt_nxt;
    end
  end

  assign O_SLOT_FIRE = (slot_st_r == SLOT_FIRE);

  // Probe pin routing
  crsf_probe_mux i_crsf_probe_mux (
    .i_clk(I_SYS_CLK),
    .i_rst(I_SYS_RST),
    .i_sel(probe_sel_r[SEL_W-1:0]),
    .i_envelope(I_ENVELOPE),
    .i_serial_data(I_SERIAL_DATA),
    .i_carrier_demod(I_CARRIER_DEMOD),
    .i_subcarrier_demod(I_SUBCARRIER_DEMOD),
    .o_probe_pin(O_PROBE_PIN)
  );

  // FIFO watermark alerts
  crsf_level_alert #(
    .DEPTH(FIFO_DEPTH)
  ) i_crsf_level_alert (
    .i_clk(I_SYS_CLK),
    .i_rst(I_SYS_RST),
    .i_watermark(watermark_r[WM_W-1:0]),
    .i_fifo_count(I_FIFO_COUNT),
    .o_near_full(O_NEAR_FULL_FLAG),
    .o_near_empty(O_NEAR_EMPTY_FLAG)
  );

  property p_reset_vals;
    @(posedge I_SYS_CLK) disable iff (I_SYS_RST)
    $fell(I_SYS_RST) |-> (seed_low_r == RST_SEED_LOW &&
      seed_high_r == RST_SEED_HIGH && probe_sel_r == RST_PROBE_SEL &&
      watermark_r == RST_WATERMARK && !O_PROBE_PIN);
  endproperty
  a_reset_vals:
    assert property (p_reset_vals) else $error("reset values");

  property p_crc_load;
    @(posedge I_SYS_CLK) disable iff (I_SYS_RST)
    (I_CRC_EN && (I_TX_BEGIN || I_RX_BEGIN || I_CALC_CMD)) |=> O_CRC_LOAD;
  endproperty
  a_crc_load: assert property (p_crc_load) else $error("no crc load");

  property p_no_load;
    @(posedge I_SYS_CLK) disable iff (I_SYS_RST)
    !I_CRC_EN |=> !O_CRC_LOAD;
  endproperty
  a_no_load: assert property (p_no_load) else $error("load while off");

  property p_seed_short;
    @(posedge I_SYS_CLK) disable iff (I_SYS_RST)
    (crc_event && I_SHORT_MODE) |=>
      (O_CRC_SEED == {8'h00, $past(seed_low_r)});
  endproperty
  a_seed_short: assert property (p_seed_short) else $error("short seed");

  property p_seed_full;
    @(posedge I_SYS_CLK) disable iff (I_SYS_RST)
    (crc_event && !I_SHORT_MODE) |=>
      (O_CRC_SEED == {$past(seed_high_r), $past(seed_low_r)});
  endproperty
  a_seed_full: assert property (p_seed_full) else $error("full seed");

  // Seed only moves at a load, so a late write waits for the next event
  property p_seed_hold;
    @(posedge I_SYS_CLK) disable iff (I_SYS_RST)
    !crc_event |=> $stable(O_CRC_SEED);
  endproperty
  a_seed_hold: assert property (p_seed_hold) else $error("seed moved");

  // Low seed byte takes the host write on the next edge
  property p_seed_write;
    @(posedge I_SYS_CLK) disable iff (I_SYS_RST)
    (I_WR && I_ADDR == ADR_SEED_LOW) |=> (seed_low_r == $past(I_WDATA));
  endproperty
  a_seed_write: assert property (p_seed_write) else $error("seed wr");

  property p_slot_fire;
    @(posedge I_SYS_CLK) disable iff (I_SYS_RST)
    (slot_st_r == SLOT_COUNT && slot_cnt_r == SLOT_W'(1) &&
      I_SLOT_TICK && !slot_start) |=> O_SLOT_FIRE ##1 !O_SLOT_FIRE;
  endproperty
  a_slot_fire: assert property (p_slot_fire) else $error("slot fire");

  property p_slot_load;
    @(posedge I_SYS_CLK) disable iff (I_SYS_RST)
    (I_CMD_TX_END && !I_QUIT_MODE) |=>
      (slot_cnt_r == {$past(probe_sel_r[SLOT_TOP_POS]), $past(slot_r)});
  endproperty
  a_slot_load: assert property (p_slot_load) else $error("slot period");

  property p_quit_ref;
    @(posedge I_SYS_CLK) disable iff (I_SYS_RST)
    (I_QUIT_MODE && I_CMD_TX_BEGIN && period != '0) |=>
      (slot_st_r == SLOT_COUNT);
  endproperty
  a_quit_ref: assert property (p_quit_ref) else $error("quit ref");

  c_load: cover property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
    O_CRC_LOAD && O_CRC_SEED[15:8] == 8'h00);
  c_fire: cover property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
    O_SLOT_FIRE);
  c_quit: cover property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
    I_QUIT_MODE && I_CMD_TX_BEGIN && period != '0);
endmodule

/* File: bench/crsf_host_model.sv */
`timescale 1ns/1ps
// Host processor on the parallel port, strobes move at falling edges
module crsf_host_model (
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  output logic [crsf_pkg::ADDR_W-1:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_wr,
  output logic o_rd
);
  import crsf_pkg::*;
  // Quiet bus at time zero
  initial begin
    o_addr = 6'h00;
    o_wdata = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  // One-cycle write strobe to any address except ADR_RSVD_A
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    if (a == ADR_RSVD_A) begin
      return;
    end
    @(negedge i_clk);
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(negedge i_clk);
    o_wr = 1'b0;
    // Released data no longer shows the old byte
    o_wdata = ~d;
  endtask
  // Read data is registered, so it is taken one cycle after the strobe
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_rd = 1'b1;
    @(negedge i_clk);
    o_rd = 1'b0;
    d = i_rdata;
  endtask
endmodule

/* File: bench/crsf_cfg_top_bench.sv */
`timescale 1ns/1ps
module crsf_cfg_top_bench;
  import crsf_pkg::*;
  logic clk;
  logic rst;
  logic [5:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic tx, rx, calc, en, sm, load;
  logic [15:0] seed;
  logic cmd_b, cmd_e, quit, tick, fire;
  logic env, ser, car, sub, pin;
  logic [6:0] cnt;
  logic nf, ne;
  int fail_count;
  int n_tests;
  int cycles = 0;

  crsf_host_model i_crsf_host_model (.i_clk(clk), .i_rdata(rdata),
    .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));

  crsf_cfg_top i_crsf_cfg_top (.I_SYS_CLK(clk), .I_SYS_RST(rst),
    .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
    .I_TX_BEGIN(tx), .I_RX_BEGIN(rx), .I_CALC_CMD(calc), .I_CRC_EN(en),
    .I_SHORT_MODE(sm), .O_CRC_LOAD(load), .O_CRC_SEED(seed),
    .I_CMD_TX_BEGIN(cmd_b), .I_CMD_TX_END(cmd_e), .I_QUIT_MODE(quit),
    .I_SLOT_TICK(tick), .O_SLOT_FIRE(fire), .I_ENVELOPE(env),
    .I_SERIAL_DATA(ser), .I_CARRIER_DEMOD(car),
    .I_SUBCARRIER_DEMOD(sub), .O_PROBE_PIN(pin), .I_FIFO_COUNT(cnt),
    .O_NEAR_FULL_FLAG(nf), .O_NEAR_EMPTY_FLAG(ne));

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Counts and verdict, the only exit
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Four-state compare, so an unknown matches only an unknown
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Register read and compare
  task automatic rchk(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] d;
    i_crsf_host_model.rd(a, d);
    chk({8'h00, d}, {8'h00, e});
  endtask

  // Hang guard, the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      $display("[ERR] %0t run timed out", $time);
      test_done();
    end
  end

  task automatic t_reset();
    chk({15'h0, pin}, 16'h0000);
    chk({14'h0, nf, ne}, 16'h0001);
    rchk(ADR_SEED_LOW, 8'hFE);
    rchk(ADR_SEED_HIGH, 8'hFF);
    rchk(ADR_PROBE_SEL, 8'h00);
    rchk(ADR_WATERMARK, 8'h3E);
    rchk(ADR_SLOT, 8'h00);
    // Unmapped place reads as zero
    rchk(6'h28, 8'h00);
    $display("test reset done");
  endtask

  // One load cause, then the pulse and its single-cycle width
  task automatic crc_ev(input logic [2:0] ev, input logic e,
                        input logic s, input logic l, input logic [15:0] x);
    @(negedge clk);
    {calc, rx, tx} = ev;
    en = e;
    sm = s;
    @(negedge clk);
    {calc, rx, tx} = 3'h0;
    chk({15'h0, load}, {15'h0, l});
    chk(seed, x);
    @(negedge clk);
    chk({15'h0, load}, 16'h0000);
  endtask

  task automatic t_crc();
    i_crsf_host_model.wr(ADR_SEED_LOW, 8'hFF);
    i_crsf_host_model.wr(ADR_SEED_HIGH, 8'h5A);
    crc_ev(3'h1, 1'b1, 1'b0, 1'b1, 16'h5AFF);
    crc_ev(3'h4, 1'b1, 1'b1, 1'b1, 16'h00FF);
    // Disabled CRC leaves the seed alone
    crc_ev(3'h2, 1'b0, 1'b0, 1'b0, 16'h00FF);
    crc_ev(3'h2, 1'b1, 1'b0, 1'b1, 16'h5AFF);
    en = 1'b0;
    $display("test crc done");
  endtask

  // Start, tick every cycle, count cycles until the fire pulse
  task automatic slot_run(input logic q, input int p);
    int n;
    @(negedge clk);
    quit = q;
    cmd_b = q;
    cmd_e = ~q;
    @(negedge clk);
    cmd_b = 1'b0;
    cmd_e = 1'b0;
    tick = 1'b1;
    n = 0;
    while (fire !== 1'b1 && n < 600) begin
      @(negedge clk);
      n++;
    end
    tick = 1'b0;
    chk(16'(n), 16'(p));
    @(negedge clk);
    chk({15'h0, fire}, 16'h0000);
  endtask

  task automatic t_slot();
    i_crsf_host_model.wr(ADR_SLOT, 8'h03);
    slot_run(1'b0, 3);
    slot_run(1'b1, 3);
    i_crsf_host_model.wr(ADR_SLOT, 8'h00);
    i_crsf_host_model.wr(ADR_PROBE_SEL, 8'h10);
    slot_run(1'b0, 256);
    quit = 1'b0;
    $display("test slot done");
  endtask

  task automatic t_probe();
    logic [7:0] tbl;
    for (int c = 0; c < 8; c++) begin
      i_crsf_host_model.wr(ADR_PROBE_SEL, {5'h00, 3'(c)});
      for (int v = 0; v < 2; v++) begin
        @(negedge clk);
        {sub, car, ser, env} = (v == 1) ? 4'hA : 4'h5;
        @(negedge clk);
        // Reserved codes drive low
        tbl = {2'h0, sub, car, ser, env, 2'h2};
        chk({15'h0, pin}, {15'h0, tbl[c]});
      end
    end
    $display("test probe done");
  endtask

  task automatic t_alert();
    logic [6:0] cl [8] = '{0, 1, 5, 6, 58, 59, 63, 64};
    logic [6:0] wm [2] = '{5, 63};
    foreach (wm[w]) begin
      i_crsf_host_model.wr(ADR_WATERMARK, {2'h0, wm[w][5:0]});
      foreach (cl[k]) begin
        @(negedge clk);
        cnt = cl[k];
        @(negedge clk);
        chk({15'h0, nf}, {15'h0, (7'd64 - cl[k]) <= wm[w]});
        chk({15'h0, ne}, {15'h0, cl[k] <= wm[w]});
      end
    end
    $display("test alert done");
  endtask

  // Main sequence
  initial begin
    fail_count = 0;
    n_tests = 0;
    rst = 1'b1;
    {tx, rx, calc, en, sm} = 5'h00;
    {cmd_b, cmd_e, quit, tick} = 4'h0;
    {env, ser, car, sub} = 4'h0;
    cnt = 7'h00;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_reset();
    t_crc();
    t_slot();
    t_probe();
    t_alert();
    test_done();
  end
endmodule
